// ---- hdl/dbsi_top.sv ----
`timescale 1ns/1ps
module dbsi_top (
  // system clock and reset
  input  wire logic                 CLK,
  input  wire logic                 RSTN,
  // link clocks
  input  wire logic                 K_CLK,
  input  wire logic                 K_N_CLK,
  // control and address
  input  wire logic                 LOAD_STROBE_N,
  input  wire logic                 READ_WRITE_SELECT,
  input  wire dbsi_pkg::dbsi_addr_t ADDR,
  input  wire dbsi_pkg::dbsi_be_t   BYTE_WRITE_SELECT_N,
  input  wire logic                 PLL_DISABLE_N,
  // data bus, split
  input  wire dbsi_pkg::dbsi_word_t DQ_I,
  output dbsi_pkg::dbsi_word_t      DQ_O,
  output logic                      DQ_OE_N,
  // read timing
  output logic                      OUTPUT_VALID,
  output logic                      ECHO_TIMING_OUT,
  output logic                      ECHO_TIMING_OUT_N,
  // system side status
  output logic                      READ_SEEN,
  output logic                      WRITE_SEEN,
  output logic                      PLL_MODE_ON
);
  dbsi_kn_if kif ();

  dbsi_pkg::dbsi_word_t mem_a [0:dbsi_pkg::DEPTH-1];
  dbsi_pkg::dbsi_word_t mem_b [0:dbsi_pkg::DEPTH-1];

  logic                 pll_s1_q;
  logic                 pll_s2_q;
  logic                 pll_off;
  logic                 ld;
  logic                 ld_rd;
  logic                 ld_wr;
  logic                 rd1_v_q;
  dbsi_pkg::dbsi_addr_t rd1_a_q;
  logic                 wr1_v_q;
  dbsi_pkg::dbsi_addr_t wr1_a_q;
  logic                 wr2_v_q;
  dbsi_pkg::dbsi_addr_t wr2_a_q;
  dbsi_pkg::dbsi_word_t w0_q;
  dbsi_pkg::dbsi_be_t   w0_be_n_q;
  logic                 byp_hit;
  dbsi_pkg::dbsi_word_t fetch0;
  dbsi_pkg::dbsi_word_t fetch1;
  logic                 rd2_v_q;
  dbsi_pkg::dbsi_word_t rd2_d0_q;
  dbsi_pkg::dbsi_word_t rd2_d1_q;
  logic                 rd3_v_q;
  dbsi_pkg::dbsi_word_t rd3_d0_q;
  dbsi_pkg::dbsi_word_t rd3_d1_q;
  logic                 k_v_q;
  dbsi_pkg::dbsi_word_t k_word_q;
  logic                 echo_k_q;
  logic                 rd_tgl_q;
  logic                 wr_tgl_q;
  logic                 drive;
  logic                 k_rst_s1_q;
  logic                 k_rst_n_q;

  // link-side reset asserts at once but releases on a master rise,
  // so no flop on k_rst_n_q sees the release close to its own edge; mode and toggle flops take RSTN directly
  always_ff @(posedge K_CLK or negedge RSTN) begin
    if (!RSTN) begin
      k_rst_s1_q <= 1'b0;
      k_rst_n_q  <= 1'b0;
    end else begin
      k_rst_s1_q <= 1'b1;
      k_rst_n_q  <= k_rst_s1_q;
    end
  end

  // mode pin is static, still passed through two flops
  always_ff @(posedge K_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pll_s1_q <= 1'b1;
      pll_s2_q <= 1'b1;
    end else begin
      pll_s1_q <= PLL_DISABLE_N;
      pll_s2_q <= pll_s1_q;
    end
  end
  assign pll_off = ~pll_s2_q;

  assign ld    = ~LOAD_STROBE_N;
  assign ld_rd = ld & READ_WRITE_SELECT;
  assign ld_wr = ld & ~READ_WRITE_SELECT;

  // address and direction taken at the master rise
  always_ff @(posedge K_CLK or negedge k_rst_n_q) begin
    if (!k_rst_n_q) begin
      rd1_v_q <= 1'b0;
      rd1_a_q <= dbsi_pkg::ADDR_RST;
      wr1_v_q <= 1'b0;
      wr1_a_q <= dbsi_pkg::ADDR_RST;
    end else begin
      rd1_v_q <= ld_rd;
      wr1_v_q <= ld_wr;
      if (ld) begin
        rd1_a_q <= ADDR;
        wr1_a_q <= ADDR;
      end
    end
  end

  // first write word one cycle after load, second on the next inverted rise
  always_ff @(posedge K_CLK or negedge k_rst_n_q) begin
    if (!k_rst_n_q) begin
      wr2_v_q   <= 1'b0;
      wr2_a_q   <= dbsi_pkg::ADDR_RST;
      w0_q      <= dbsi_pkg::WORD_RST;
      w0_be_n_q <= dbsi_pkg::BE_NONE;
    end else begin
      wr2_v_q <= wr1_v_q;
      if (wr1_v_q) begin
        wr2_a_q   <= wr1_a_q;
        w0_q      <= DQ_I;
        w0_be_n_q <= BYTE_WRITE_SELECT_N;
      end
    end
  end

  assign kif.wr_arm  = wr2_v_q;
  assign kif.dq_in   = DQ_I;
  assign kif.be_n_in = BYTE_WRITE_SELECT_N;

  // commit both words once the pair is complete; arrays carry no reset
  always_ff @(posedge K_CLK) begin
    if (wr2_v_q) begin
      mem_a[wr2_a_q] <= dbsi_pkg::dbsi_merge(mem_a[wr2_a_q], w0_q, w0_be_n_q);
      mem_b[wr2_a_q] <= dbsi_pkg::dbsi_merge(mem_b[wr2_a_q], kif.w1_data, kif.w1_be_n);
    end
  end

  // write committing now is not yet in the array, so forward it
  assign byp_hit = wr2_v_q && (wr2_a_q == rd1_a_q) && rd1_v_q;
  always_comb begin
    fetch0 = mem_a[rd1_a_q];
    fetch1 = mem_b[rd1_a_q];
    if (byp_hit) begin
      fetch0 = dbsi_pkg::dbsi_merge(mem_a[rd1_a_q], w0_q, w0_be_n_q);
      fetch1 = dbsi_pkg::dbsi_merge(mem_b[rd1_a_q], kif.w1_data, kif.w1_be_n);
    end
  end

  // read pipeline: both words fetched together, one per array
  always_ff @(posedge K_CLK or negedge k_rst_n_q) begin
    if (!k_rst_n_q) begin
      rd2_v_q  <= 1'b0;
      rd2_d0_q <= dbsi_pkg::WORD_RST;
      rd2_d1_q <= dbsi_pkg::WORD_RST;
      rd3_v_q  <= 1'b0;
      rd3_d0_q <= dbsi_pkg::WORD_RST;
      rd3_d1_q <= dbsi_pkg::WORD_RST;
    end else begin
      rd2_v_q  <= rd1_v_q;
      rd2_d0_q <= fetch0;
      rd2_d1_q <= fetch1;
      rd3_v_q  <= rd2_v_q;
      rd3_d0_q <= rd2_d0_q;
      rd3_d1_q <= rd2_d1_q;
    end
  end

  // master-rise output word: first word in slow mode, second in fast mode
  always_ff @(posedge K_CLK or negedge k_rst_n_q) begin
    if (!k_rst_n_q) begin
      k_v_q    <= 1'b0;
      k_word_q <= dbsi_pkg::WORD_RST;
    end else begin
      k_v_q    <= pll_off ? rd1_v_q : rd3_v_q;
      k_word_q <= pll_off ? fetch0 : rd3_d1_q;
    end
  end

  // inverted-rise word: second in slow mode, first in fast mode
  assign kif.src_v    = pll_off ? rd2_v_q : rd3_v_q;
  assign kif.src_word = pll_off ? rd2_d1_q : rd3_d0_q;

  dbsi_kn_stage u_kn (
    .k_n_clk (K_N_CLK),
    .rst_n   (k_rst_n_q),
    .kif     (kif)
  );

  // echo clocks start with the first master rise after reset
  always_ff @(posedge K_CLK or negedge k_rst_n_q) begin
    if (!k_rst_n_q) begin
      echo_k_q <= 1'b0;
    end else begin
      echo_k_q <= 1'b1;
    end
  end

  // ddr output: clock level picks the half; a mode change mid-read may glitch
  assign drive             = K_CLK ? k_v_q : kif.out_v;
  assign DQ_O              = K_CLK ? k_word_q : kif.out_word;
  assign DQ_OE_N           = ~drive;
  assign OUTPUT_VALID      = drive;
  assign ECHO_TIMING_OUT   = K_CLK & echo_k_q;
  assign ECHO_TIMING_OUT_N = ~K_CLK & echo_k_q;

  // event toggles for the system domain
  always_ff @(posedge K_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rd_tgl_q <= 1'b0;
      wr_tgl_q <= 1'b0;
    end else begin
      rd_tgl_q <= rd_tgl_q ^ ld_rd;
      wr_tgl_q <= wr_tgl_q ^ ld_wr;
    end
  end

  dbsi_evt_sync u_sync (
    .clk      (CLK),
    .rst_n    (RSTN),
    .rd_tgl   (rd_tgl_q),
    .wr_tgl   (wr_tgl_q),
    .pll_on   (pll_s2_q),
    .rd_seen  (READ_SEEN),
    .wr_seen  (WRITE_SEEN),
    .pll_mode (PLL_MODE_ON)
  );

  default clocking dbsi_cb @(posedge K_CLK);
  endclocking
  default disable iff (!k_rst_n_q);

  // a flop set at an edge is only seen at the next tick, hence one cycle more
  lat_slow_a: assert property (
    (ld_rd && pll_off) |-> ##2 k_v_q)
    else $error("slow mode read not driven after one cycle");

  lat_fast_a: assert property (
    (ld_rd && !pll_off) |-> ##4 k_v_q)
    else $error("fast mode read not driven at three cycles");

  two_words_a: assert property (
    (ld_rd && !pll_off) |-> ##4 (k_word_q == $past(fetch1, 3)))
    else $error("second read word differs from fetched word");

  slow_word0_a: assert property (
    (ld_rd && pll_off) |-> ##2 (k_word_q == $past(fetch0)))
    else $error("slow mode first word differs from fetched word");

  slow_word1_a: assert property (
    (ld_rd && pll_off) |-> ##2 (kif.out_v && kif.out_word == $past(fetch1)))
    else $error("slow mode second word missing or wrong");

  fast_word0_a: assert property (
    (ld_rd && !pll_off) |-> ##3 (kif.out_v && kif.out_word == $past(fetch0, 2)))
    else $error("fast mode first word missing or wrong");

  quiet_bus_a: assert property (
    (!rd1_v_q && !rd3_v_q) |=> !k_v_q)
    else $error("data driven with no read pending");

  addr_take_a: assert property (
    ld_rd |=> (rd1_v_q && rd1_a_q == $past(ADDR)))
    else $error("read address not taken at load");

  wr_commit_a: assert property (
    ld_wr |-> ##2 (wr2_v_q && wr2_a_q == $past(ADDR, 2)))
    else $error("write not committed two cycles after load");

  be_take_a: assert property (
    wr1_v_q |=> (w0_be_n_q == $past(BYTE_WRITE_SELECT_N) && w0_q == $past(DQ_I)))
    else $error("first write word or selects not captured");

  bypass_new_a: assert property (
    byp_hit |=> (rd2_d0_q == mem_a[$past(rd1_a_q)] && rd2_d1_q == mem_b[$past(rd1_a_q)]))
    else $error("forwarded read differs from committed data");

  echo_run_a: assert property (
    k_v_q |-> echo_k_q)
    else $error("read data with echo clocks stopped");

  word_hold_a: assert property (
    !wr1_v_q |=> ($stable(w0_q) && $stable(w0_be_n_q)))
    else $error("first write word changed with no write pending");

  addr_hold_a: assert property (
    !ld |=> ($stable(rd1_a_q) && $stable(wr1_a_q)))
    else $error("address register changed with no load");

  rd_event_a: assert property (
    ld_rd |=> (rd_tgl_q != $past(rd_tgl_q)))
    else $error("read load not passed to system side");

  wr_event_a: assert property (
    ld_wr |=> (wr_tgl_q != $past(wr_tgl_q)))
    else $error("write load not passed to system side");

  echo_hold_a: assert property (
    echo_k_q |=> echo_k_q)
    else $error("echo clocks stopped after starting");

  rd_fast_c: cover property (ld_rd && !pll_off ##4 k_v_q);
  rd_slow_c: cover property (ld_rd && pll_off ##2 k_v_q);
  wr_pair_c: cover property (ld_wr ##2 wr2_v_q);
  bypass_c:  cover property (byp_hit);
  chain_c:   cover property (ld_wr ##1 ld_rd);
endmodule

// ---- hdl/dbsi_pkg.sv ----
// Operation
// - write data taken on both clock rises
// - read data driven on both clock rises
// - data drivers float when no read
// - low load strobe starts cycle, takes address
// - every access moves exactly two words
// - byte selects active low, sampled with data
// - each byte select gates one nine-bit lane
// - deselected lane leaves stored byte unchanged
// - shared address sampled on master clock rise
// - storage is two arrays, one per word
// - select high reads, low writes
// - valid flag marks data, aligned with echo
// - accesses start only on master clock rise
// - echo clocks run freely with master clock
// - low pll disable selects slow mode
// - latency 2.5 cycles, or 1 when disabled
// - read after write returns newest data
package dbsi_pkg;
  localparam int ADDR_W          = 20;
  localparam int LANE_W          = 9;
  localparam int LANES           = 2;
  localparam int DATA_W          = LANES * LANE_W;
  localparam int DEPTH           = 1 << ADDR_W;
  localparam int CLK_FREQ_MHZ    = 50;
  localparam int PLL_OFF_MAX_MHZ = 167;

  typedef logic [DATA_W-1:0] dbsi_word_t;
  typedef logic [ADDR_W-1:0] dbsi_addr_t;
  typedef logic [LANES-1:0]  dbsi_be_t;

  localparam dbsi_word_t WORD_RST = 18'h00000;
  localparam dbsi_addr_t ADDR_RST = 20'h00000;
  localparam dbsi_be_t   BE_NONE  = 2'h3;

  // lane-wise merge of new data over old under active-low selects
  function automatic dbsi_word_t dbsi_merge(dbsi_word_t old_w, dbsi_word_t new_w,
                                            dbsi_be_t be_n);
    dbsi_word_t res;
    res = old_w;
    for (int i = 0; i < LANES; i++) begin
      if (!be_n[i]) begin
        res[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
      end
    end
    return res;
  endfunction
endpackage

// ---- hdl/dbsi_kn_if.sv ----
`timescale 1ns/1ps
interface dbsi_kn_if;
  logic                wr_arm;
  dbsi_pkg::dbsi_word_t dq_in;
  dbsi_pkg::dbsi_be_t   be_n_in;
  dbsi_pkg::dbsi_word_t w1_data;
  dbsi_pkg::dbsi_be_t   w1_be_n;
  logic                src_v;
  dbsi_pkg::dbsi_word_t src_word;
  logic                out_v;
  dbsi_pkg::dbsi_word_t out_word;

  modport core (output wr_arm, dq_in, be_n_in, src_v, src_word,
                input  w1_data, w1_be_n, out_v, out_word);
  modport kn   (input  wr_arm, dq_in, be_n_in, src_v, src_word,
                output w1_data, w1_be_n, out_v, out_word);
endinterface

// ---- hdl/dbsi_kn_stage.sv ----
`timescale 1ns/1ps
module dbsi_kn_stage (
  // inverted link clock and reset
  input wire logic k_n_clk,
  input wire logic rst_n,
  // link to core
  dbsi_kn_if.kn    kif
);
  // second write word and its selects
  always_ff @(posedge k_n_clk or negedge rst_n) begin
    if (!rst_n) begin
      kif.w1_data <= dbsi_pkg::WORD_RST;
      kif.w1_be_n <= dbsi_pkg::BE_NONE;
    end else if (kif.wr_arm) begin
      kif.w1_data <= kif.dq_in;
      kif.w1_be_n <= kif.be_n_in;
    end
  end

  // half-cycle output word
  always_ff @(posedge k_n_clk or negedge rst_n) begin
    if (!rst_n) begin
      kif.out_v    <= 1'b0;
      kif.out_word <= dbsi_pkg::WORD_RST;
    end else begin
      kif.out_v    <= kif.src_v;
      kif.out_word <= kif.src_word;
    end
  end
endmodule

// ---- hdl/dbsi_evt_sync.sv ----
`timescale 1ns/1ps
module dbsi_evt_sync (
  // system clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // from link domain
  input  wire logic rd_tgl,
  input  wire logic wr_tgl,
  input  wire logic pll_on,
  // system side
  output logic      rd_seen,
  output logic      wr_seen,
  output logic      pll_mode
);
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic [2:0] s3_q;

  // toggles carry events, level carries mode; s1 feeds only s2
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
    end else begin
      s1_q <= {pll_on, wr_tgl, rd_tgl};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_seen  <= 1'b0;
      wr_seen  <= 1'b0;
      pll_mode <= 1'b0;
    end else begin
      rd_seen  <= s2_q[0] ^ s3_q[0];
      wr_seen  <= s2_q[1] ^ s3_q[1];
      pll_mode <= s2_q[2];
    end
  end
endmodule

// ---- testbench/dbsi_host_model.sv ----
`timescale 1ns/1ps
module dbsi_host_model (
  // link clocks
  output logic                      k_clk,
  output logic                      k_n_clk,
  // control, address, write data
  output logic                      load_strobe_n,
  output logic                      rw_sel,
  output dbsi_pkg::dbsi_addr_t      addr,
  output dbsi_pkg::dbsi_be_t        be_n,
  output dbsi_pkg::dbsi_word_t      dq,
  // resolved data wire and read timing
  input  wire dbsi_pkg::dbsi_word_t dq_wire,
  input  wire logic                 valid,
  input  wire logic                 oe_n
);
  // link clock runs on, device pipeline and echo depend on it
  initial begin
    k_clk = 1'b0;
    load_strobe_n = 1'b1;
    rw_sel = 1'b0;
    addr = 20'h00000;
    be_n = 2'h3;
    dq = 18'h00000;
  end
  always #16 k_clk = ~k_clk;
  assign k_n_clk = ~k_clk;

  // chain: the load slot after this write carries a read of ra
  task automatic write_pair(input dbsi_pkg::dbsi_addr_t a, input dbsi_pkg::dbsi_word_t w0, w1,
                            input dbsi_pkg::dbsi_be_t b0, b1, input logic chain,
                            input dbsi_pkg::dbsi_addr_t ra);
    @(posedge k_clk) load_strobe_n <= 1'b0;
    rw_sel <= 1'b0;
    addr <= a;
    @(posedge k_clk) load_strobe_n <= ~chain;
    rw_sel <= chain;
    addr <= ra;
    dq <= w0;
    be_n <= b0;
    @(posedge k_clk) load_strobe_n <= 1'b1;
    dq <= w1;
    be_n <= b1;
    // released bus shows the inverse, never a stale word
    @(posedge k_n_clk) dq <= ~w1;
    be_n <= 2'h3;
  endtask

  // pre: load already issued by a chained write
  task automatic read_pair(input dbsi_pkg::dbsi_addr_t a, input logic fast, pre,
                           output dbsi_pkg::dbsi_word_t d0, d1, output logic v0, ve, o0);
    if (!pre) begin
      @(posedge k_clk) load_strobe_n <= 1'b0;
      rw_sel <= 1'b1;
      addr <= a;
      @(posedge k_clk) load_strobe_n <= 1'b1;
    end
    if (fast) begin
      repeat (2) @(posedge k_clk);
      @(posedge k_n_clk);
    end else begin
      @(posedge k_clk);
    end
    #8 d0 = dq_wire;
    v0 = valid;
    o0 = oe_n;
    if (fast) @(posedge k_clk);
    else @(posedge k_n_clk);
    #8 d1 = dq_wire;
    if (fast) @(posedge k_n_clk);
    else @(posedge k_clk);
    #8 ve = valid;
    // callers add no wait; these waits leave three idle load slots before a next write, four in fast mode
  endtask
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  logic                 CLK, RSTN, PLL_DISABLE_N;
  logic                 k_clk, k_n_clk, ld_n, rw, oe_n, valid, echo, echo_n;
  logic                 rd_seen, wr_seen, pll_on, v0, ve, o0;
  dbsi_pkg::dbsi_addr_t addr;
  dbsi_pkg::dbsi_addr_t slot [8];
  dbsi_pkg::dbsi_be_t   be_n;
  dbsi_pkg::dbsi_word_t host_dq, dq_o, dq_wire, d0, d1, w0, w1;
  dbsi_pkg::dbsi_word_t m0 [8];
  dbsi_pkg::dbsi_word_t m1 [8];
  int                   miscompares, cmp_count, rd_cnt, wr_cnt, exp_rd, exp_wr;

  assign dq_wire = (oe_n === 1'b0) ? dq_o : host_dq;
  always #10 CLK = ~CLK;
  always @(negedge CLK) begin
    if (rd_seen === 1'b1) rd_cnt++;
    if (wr_seen === 1'b1) wr_cnt++;
  end

  dbsi_host_model i_host (.k_clk(k_clk), .k_n_clk(k_n_clk), .load_strobe_n(ld_n),
    .rw_sel(rw), .addr(addr), .be_n(be_n), .dq(host_dq), .dq_wire(dq_wire),
    .valid(valid), .oe_n(oe_n));
  dbsi_top i_dut (.CLK(CLK), .RSTN(RSTN), .K_CLK(k_clk), .K_N_CLK(k_n_clk),
    .LOAD_STROBE_N(ld_n), .READ_WRITE_SELECT(rw), .ADDR(addr), .BYTE_WRITE_SELECT_N(be_n),
    .PLL_DISABLE_N(PLL_DISABLE_N), .DQ_I(dq_wire), .DQ_O(dq_o), .DQ_OE_N(oe_n),
    .OUTPUT_VALID(valid), .ECHO_TIMING_OUT(echo), .ECHO_TIMING_OUT_N(echo_n),
    .READ_SEEN(rd_seen), .WRITE_SEEN(wr_seen), .PLL_MODE_ON(pll_on));

  function automatic dbsi_pkg::dbsi_word_t lane_mix(dbsi_pkg::dbsi_word_t o, n,
                                                    dbsi_pkg::dbsi_be_t b);
    lane_mix = o;
    if (b[0] == 1'b0) lane_mix[8:0] = n[8:0];
    if (b[1] == 1'b0) lane_mix[17:9] = n[17:9];
  endfunction

  task automatic wr(input int s, input dbsi_pkg::dbsi_be_t b0, b1, input logic chain);
    w0 = 18'($urandom());
    w1 = 18'($urandom());
    i_host.write_pair(slot[s], w0, w1, b0, b1, chain, slot[s]);
    m0[s] = lane_mix(m0[s], w0, b0);
    m1[s] = lane_mix(m1[s], w1, b1);
    exp_wr++;
  endtask

  task automatic rd(input int s, input logic pre);
    i_host.read_pair(slot[s], PLL_DISABLE_N, pre, d0, d1, v0, ve, o0);
    `CHK("word0", m0[s], d0)
    `CHK("word1", m1[s], d1)
    `CHK("valid", 1'b1, v0)
    `CHK("valid_end", 1'b0, ve)
    `CHK("oe_n", 1'b0, o0)
    exp_rd++;
  endtask

  task automatic conclude();
    $display("counts: %0d compares, %0d mismatches", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #400000;
    miscompares++;
    $display("mismatch run_time expected end seen hang");
    conclude();
  end

  initial begin
    CLK = 1'b0;
    RSTN = 1'b0;
    PLL_DISABLE_N = 1'b1;
    void'($urandom(94469));
    repeat (4) @(posedge CLK);
    RSTN <= 1'b1;
    for (int i = 0; i < 8; i++) slot[i] = {17'($urandom()), 3'(i)};
    repeat (4) @(posedge k_clk);
    repeat (3) begin
      @(posedge k_clk);
      #4 `CHK("echo", 1'b1, echo)
      `CHK("echo_n", 1'b0, echo_n)
      `CHK("idle_oe_n", 1'b1, oe_n)
      @(negedge k_clk);
      #4 `CHK("echo_lo", 1'b0, echo)
      `CHK("echo_n_lo", 1'b1, echo_n)
    end
    $display("test echo done");
    for (int i = 0; i < 8; i++) wr(i, 2'h0, 2'h0, 1'b0);
    for (int i = 0; i < 8; i++) rd(i, 1'b0);
    $display("test fill done");
    for (int b = 0; b < 4; b++) begin
      wr(1, 2'(b), 2'(~b), 1'b0);
      rd(1, 1'b0);
    end
    $display("test lanes done");
    for (int p = 1; p >= 0; p--) begin
      @(posedge CLK) PLL_DISABLE_N <= 1'(p);
      repeat (6) @(posedge k_clk);
      `CHK("pll_mode", 1'(p), pll_on)
      wr(2, 2'h0, 2'h0, 1'b1);
      rd(2, 1'b1);
      repeat (30) begin
        if ($urandom() % 2 == 0) wr($urandom() % 8, 2'($urandom()), 2'($urandom()), 1'b0);
        else rd($urandom() % 8, 1'b0);
      end
      $display("test mode %0d done", p);
    end
    repeat (20) @(posedge CLK);
    `CHK("reads_seen", exp_rd, rd_cnt)
    `CHK("writes_seen", exp_wr, wr_cnt)
    conclude();
  end
endmodule
